// file: inc/adcrg_cfg.svh
// offsets, field positions, reset values and timing counts of the converter register block
//
// Overview of operation
// - any status/control write starts a conversion and clears done flag, dropping interrupt, unless a completion lands on the same edge
// - done flag at bit 7 is read-only and set by each finished conversion
// - reading either result register clears the done flag unless a conversion completes on the same edge
// - interrupt enable at bit 6 raises the interrupt on completion
// - interrupt stays pending while the done flag stays set
// - result registers hold the new data when the interrupt rises
// - system reset clears any pending conversion interrupt
// - continuous bit 5 set converts repeatedly, updating results every time
// - continuous bit clear gives exactly one conversion per status/control write
// - channel select bits 4:0, codes 00-07 pick analog inputs zero to seven
// - codes 08-1D and 1F convert low reference, 1E converts high reference
// - left justified puts result 9:2 in high 7:0, 1:0 in low 7:6
// - right justified puts result 9:8 in high 1:0, 7:0 in low 7:0
// - justification of a 10-bit result follows the justify select bit
// - eight-bit result sits in high 7:0 and low register reads zero
// - in 10-bit mode the six unused result bits read zero
// - both result registers are read-only; writes leave them unchanged
// - pin enable write aborts a running conversion and starts none
// - disabled pin converts low reference and yields zero results except high bit 7 set when signed select acts
// - signed select acts only when left justified; right justified is unsigned
// - converter control write aborts a running conversion and starts none
// - status/control write during a conversion aborts it and starts afresh
`ifndef ADCRG_CFG_SVH
`define ADCRG_CFG_SVH

// register byte offsets
`define ADC_OFS_CSC   8'h00
`define ADC_OFS_RHI   8'h04
`define ADC_OFS_RLO   8'h08
`define ADC_OFS_PE    8'h0c
`define ADC_OFS_CC    8'h10

// status/control fields
`define ADC_CSC_FLAG  7
`define ADC_CSC_IE    6
`define ADC_CSC_CONT  5
// converter control fields
`define ADC_CC_JUST   0
`define ADC_CC_SGN    1
`define ADC_CC_EIGHT_BIT_RESOLUTION   2

// reset values
`define ADC_PE_RST    8'h00
`define ADC_CC_RST    3'h0

// channel codes and reference codes
`define ADC_CH_HIREF  5'h1e
`define ADC_CODE_HI   10'h3ff
`define ADC_CODE_LO   10'h000

// bus responses
`define ADC_RESP_OK   2'h0
`define ADC_RESP_ERR  2'h2

// conversion time
`define ADC_CLK_MHZ   100
`define ADC_CONV_NS   1000
`define ADC_CONV_CYC  ((`ADC_CONV_NS * `ADC_CLK_MHZ + 999) / 1000)
`define ADC_CONV_LAST (8'(`ADC_CONV_CYC - 1))

`endif

// file: inc/adcrg_pkg.sv
// types of the converter register block
package adcrg_pkg;

  // conversion sequencer
  typedef enum logic {
    ADCRG_IDLE,
    ADCRG_BUSY
  } adcrg_conv_t;

  // decoded register select
  typedef enum logic [2:0] {
    ADCRG_SEL_CSC,
    ADCRG_SEL_RHI,
    ADCRG_SEL_RLO,
    ADCRG_SEL_PE,
    ADCRG_SEL_CC,
    ADCRG_SEL_NONE
  } adcrg_sel_t;

  // formatted result pair
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } adcrg_res_t;

  // whole state of the block
  typedef struct packed {
    adcrg_conv_t      conv;
    logic [7:0]       cnt;
    logic             flag;
    logic             ie;
    logic             cont;
    logic [4:0]       ch;
    logic [7:0]       pe;
    logic [2:0]       cc;
    adcrg_res_t       res;
    logic             irq;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             aw_have;
    logic             w_have;
    logic [7:0]       aw_addr;
    logic [7:0]       w_data;
    logic             w_lane;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [7:0]       rdata;
    logic [7:0][9:0]  ain_m;
    logic [7:0][9:0]  ain_s;
  } adcrg_state_t;

endpackage

// file: rtl/adcrg_top.sv
// converter status/control, result and pin enable registers behind an AXI4-Lite slave
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`include "adcrg_cfg.svh"

module adcrg_top (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             awvalid,
  output logic                  awready,
  input  wire logic [7:0]       awaddr,
  input  wire logic [2:0]       awprot,
  input  wire logic             wvalid,
  output logic                  wready,
  input  wire logic [31:0]      wdata,
  input  wire logic [3:0]       wstrb,
  output logic                  bvalid,
  input  wire logic             bready,
  output logic [1:0]            bresp,
  input  wire logic             arvalid,
  output logic                  arready,
  input  wire logic [7:0]       araddr,
  input  wire logic [2:0]       arprot,
  output logic                  rvalid,
  input  wire logic             rready,
  output logic [31:0]           rdata,
  output logic [1:0]            rresp,
  input  wire logic [7:0][9:0]  ain_code,
  output logic                  conv_irq
);

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------

  // address to register; shared by the read and the write path
  function automatic adcrg_pkg::adcrg_sel_t reg_sel(input logic [7:0] a);
    adcrg_pkg::adcrg_sel_t s;
    unique case (a)
      `ADC_OFS_CSC: s = adcrg_pkg::ADCRG_SEL_CSC;
      `ADC_OFS_RHI: s = adcrg_pkg::ADCRG_SEL_RHI;
      `ADC_OFS_RLO: s = adcrg_pkg::ADCRG_SEL_RLO;
      `ADC_OFS_PE:  s = adcrg_pkg::ADCRG_SEL_PE;
      `ADC_OFS_CC:  s = adcrg_pkg::ADCRG_SEL_CC;
      default:      s = adcrg_pkg::ADCRG_SEL_NONE;
    endcase
    return s;
  endfunction

  // level presented to the converter for a channel code
  function automatic logic [9:0] chan_level(input logic [4:0]      ch,
                                            input logic [7:0]      pe,
                                            input logic [7:0][9:0] ain);
    logic [9:0] v;
    v = `ADC_CODE_LO;
    if (ch[4:3] == 2'h0) begin
      if (pe[ch[2:0]]) begin
        v = ain[ch[2:0]];
      end
    end else if (ch == `ADC_CH_HIREF) begin
      v = `ADC_CODE_HI;
    end
    return v;
  endfunction

  // place a raw 10-bit code into the high/low result pair
  function automatic adcrg_pkg::adcrg_res_t fmt_res(input logic [9:0] raw,
                                                    input logic [2:0] cc);
    adcrg_pkg::adcrg_res_t r;
    logic [9:0]            v;
    v = raw;
    // offset binary: the sign is the inverted msb, only when left justified
    if (cc[`ADC_CC_SGN] && !cc[`ADC_CC_JUST]) begin
      v[9] = ~raw[9];
    end
    if (cc[`ADC_CC_EIGHT_BIT_RESOLUTION]) begin
      r.hi = v[9:2];
      r.lo = 8'h00;
    end else if (cc[`ADC_CC_JUST]) begin
      r.hi = {6'h00, raw[9:8]};
      r.lo = raw[7:0];
    end else begin
      r.hi = v[9:2];
      r.lo = {v[1:0], 6'h00};
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------

  adcrg_pkg::adcrg_state_t q;
  adcrg_pkg::adcrg_state_t d;
  adcrg_pkg::adcrg_sel_t   wsel;
  adcrg_pkg::adcrg_sel_t   rsel;
  logic                    wr_fire;
  logic                    wr_en;
  logic                    rd_fire;
  logic                    csc_wr;
  logic                    pe_wr;
  logic                    cc_wr;
  logic                    res_wr;
  logic                    res_rd;
  logic                    conv_done;

  // next state: bus slave, register effects and conversion sequencer
  always_comb begin
    d         = q;
    wsel      = reg_sel(q.aw_addr);
    rsel      = reg_sel(araddr);
    wr_fire   = q.aw_have && q.w_have && !q.bvalid;
    wr_en     = wr_fire && (wsel != adcrg_pkg::ADCRG_SEL_NONE) && q.w_lane;
    rd_fire   = arvalid && q.arready;
    csc_wr    = wr_en && (wsel == adcrg_pkg::ADCRG_SEL_CSC);
    pe_wr     = wr_en && (wsel == adcrg_pkg::ADCRG_SEL_PE);
    cc_wr     = wr_en && (wsel == adcrg_pkg::ADCRG_SEL_CC);
    res_wr    = wr_en && ((wsel == adcrg_pkg::ADCRG_SEL_RHI) || (wsel == adcrg_pkg::ADCRG_SEL_RLO));
    res_rd    = rd_fire && ((rsel == adcrg_pkg::ADCRG_SEL_RHI) || (rsel == adcrg_pkg::ADCRG_SEL_RLO));
    conv_done = (q.conv == adcrg_pkg::ADCRG_BUSY) && (q.cnt == `ADC_CONV_LAST);

    // pin levels: two flops; a code may tear while the pin slews
    d.ain_m = ain_code;
    d.ain_s = q.ain_m;

    // write address and data are taken independently and paired here
    if (awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.w_data = wdata[7:0];
      d.w_lane = wstrb[0];
    end
    if (wr_fire) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = (wsel == adcrg_pkg::ADCRG_SEL_NONE) ? `ADC_RESP_ERR : `ADC_RESP_OK;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    d.awready = !d.aw_have;
    d.wready  = !d.w_have;

    // read channel: one outstanding read, data registered with rvalid
    if (rd_fire) begin
      d.rvalid = 1'b1;
      d.rresp  = `ADC_RESP_OK;
      unique case (rsel)
        adcrg_pkg::ADCRG_SEL_CSC: d.rdata = {q.flag, q.ie, q.cont, q.ch};
        adcrg_pkg::ADCRG_SEL_RHI: d.rdata = q.res.hi;
        adcrg_pkg::ADCRG_SEL_RLO: d.rdata = q.res.lo;
        adcrg_pkg::ADCRG_SEL_PE:  d.rdata = q.pe;
        adcrg_pkg::ADCRG_SEL_CC:  d.rdata = {5'h00, q.cc};
        adcrg_pkg::ADCRG_SEL_NONE: begin
          d.rdata = 8'h00;
          d.rresp = `ADC_RESP_ERR;
        end
      endcase
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    d.arready = !d.rvalid;

    // sequencer: results land in the same cycle the flag rises
    if (conv_done) begin
      d.res  = fmt_res(chan_level(q.ch, q.pe, q.ain_s), q.cc);
      d.cnt  = 8'h00;
      d.conv = q.cont ? adcrg_pkg::ADCRG_BUSY : adcrg_pkg::ADCRG_IDLE;
    end else if (q.conv == adcrg_pkg::ADCRG_BUSY) begin
      d.cnt = q.cnt + 8'h01;
    end

    // result registers ignore writes; res_wr only answers OKAY
    // abort without restart
    if (pe_wr || cc_wr) begin
      d.conv = adcrg_pkg::ADCRG_IDLE;
      d.cnt  = 8'h00;
    end
    if (pe_wr) begin
      d.pe = q.w_data;
    end
    if (cc_wr) begin
      d.cc = q.w_data[2:0];
    end
    // abort and restart
    if (csc_wr) begin
      d.ie   = q.w_data[`ADC_CSC_IE];
      d.cont = q.w_data[`ADC_CSC_CONT];
      d.ch   = q.w_data[4:0];
      d.conv = adcrg_pkg::ADCRG_BUSY;
      d.cnt  = 8'h00;
    end

    // clearing accesses first, so a completion in the same cycle wins
    if (csc_wr || res_rd) begin
      d.flag = 1'b0;
    end
    if (conv_done) begin
      d.flag = 1'b1;
    end
    d.irq = d.flag && d.ie;
  end

  // single register stage; reset clears the flag and so the interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q    <= '0;
      q.pe <= `ADC_PE_RST;
      q.cc <= `ADC_CC_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  assign awready  = q.awready;
  assign wready   = q.wready;
  assign bvalid   = q.bvalid;
  assign bresp    = q.bresp;
  assign arready  = q.arready;
  assign rvalid   = q.rvalid;
  assign rresp    = q.rresp;
  assign rdata    = {24'h000000, q.rdata};
  assign conv_irq = q.irq;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_csc_clear;
    csc_wr && !conv_done;
  endsequence

  sequence s_quiet_done;
    conv_done && !csc_wr && !pe_wr && !cc_wr;
  endsequence

  AST_CSC_WR_CLEARS: assert property (s_csc_clear |=> !q.flag && !conv_irq ##1 !conv_done[*1])
    else $error("status write did not clear flag and interrupt");

  AST_CSC_RESTART: assert property (csc_wr |=> q.conv == adcrg_pkg::ADCRG_BUSY && q.cnt == 8'h00)
    else $error("status write did not restart conversion");

  AST_DONE_SETS: assert property (conv_done |=> q.flag)
    else $error("completion did not set the flag");

  AST_RES_RD_CLEARS: assert property (res_rd && !conv_done |=> !q.flag)
    else $error("result read did not clear the flag");

  AST_IRQ_TRACKS: assert property (conv_irq == (q.flag && q.ie))
    else $error("interrupt does not follow flag and enable");

  AST_IRQ_HOLDS: assert property (conv_irq && !csc_wr && !res_rd |=> conv_irq)
    else $error("interrupt dropped while flag held");

  AST_RES_BEFORE_IRQ: assert property ($rose(conv_irq) |-> $past(conv_done) && q.res == $past(d.res))
    else $error("interrupt rose without fresh results");

  AST_RESET_IRQ: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> !conv_irq && !q.flag)
    else $error("reset left interrupt pending");

  AST_CONT: assert property ((s_quiet_done and q.cont) |=> q.conv == adcrg_pkg::ADCRG_BUSY && q.cnt == 8'h00)
    else $error("continuous mode did not re-convert");

  AST_SINGLE: assert property ((s_quiet_done and !q.cont) |=> q.conv == adcrg_pkg::ADCRG_IDLE)
    else $error("single mode converted again");

  AST_ABORT: assert property (pe_wr || cc_wr |=> q.conv == adcrg_pkg::ADCRG_IDLE)
    else $error("pin enable or control write did not abort");

  AST_EIGHT_BIT_RESOLUTION_LOW: assert property (conv_done && q.cc[`ADC_CC_EIGHT_BIT_RESOLUTION] |=> q.res.lo == 8'h00)
    else $error("eight-bit result left low byte nonzero");

  AST_RIGHT_ZERO: assert property (conv_done && q.cc == 3'h1 |=> q.res.hi[7:2] == 6'h00)
    else $error("right justified unused bits nonzero");

  AST_RO: assert property (res_wr && !conv_done |=> $stable(q.res))
    else $error("write changed a result register");

  AST_PIN_OFF: assert property (conv_done && q.ch[4:3] == 2'h0 && !q.pe[q.ch[2:0]] && q.cc == 3'h0
                                |=> q.res.hi == 8'h00 && q.res.lo == 8'h00)
    else $error("disabled pin produced nonzero result");

  // ----------------------------------------------------------------
  // bus and datapath assertions
  // ----------------------------------------------------------------

  // a write response stands unchanged until the master takes it
  AST_B_STANDS: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before it was taken");

  // read data stands until taken, so a slow master still sees it
  AST_R_STANDS: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped before it was taken");

  // only one read under way: no address taken while data waits
  AST_AR_BLOCKED: assert property (rvalid |-> !arready)
    else $error("read address ready while data pending");

  // a held write address blocks a second one until the pair executes
  AST_AW_BLOCKED: assert property (q.aw_have |-> !awready)
    else $error("write address ready while one is held");

  // the response follows the executed pair by one cycle
  AST_B_AFTER_PAIR: assert property (wr_fire |=> bvalid)
    else $error("write pair gave no response");

  // unmapped writes have no effect and answer with an error
  AST_B_ERR: assert property (wr_fire && wsel == adcrg_pkg::ADCRG_SEL_NONE |=> bresp == `ADC_RESP_ERR)
    else $error("unmapped write answered without error");

  // unmapped reads return zero with an error
  AST_R_ERR: assert property (rd_fire && rsel == adcrg_pkg::ADCRG_SEL_NONE
                              |=> rresp == `ADC_RESP_ERR && rdata == 32'h00000000)
    else $error("unmapped read answered without error");

  // upper bytes of read data are tied low
  AST_RDATA_HI: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("read data upper bytes nonzero");

  // left justified ten-bit result leaves the low six bits clear
  AST_LEFT_ZERO: assert property (conv_done && !q.cc[`ADC_CC_EIGHT_BIT_RESOLUTION] && !q.cc[`ADC_CC_JUST]
                                  |=> q.res.lo[5:0] == 6'h00)
    else $error("left justified unused bits nonzero");

  // full scale from the high reference, zero from every other reference code
  AST_HIREF: assert property (conv_done && q.ch == `ADC_CH_HIREF && q.cc == 3'h0
                              |=> q.res.hi == 8'hff && q.res.lo == 8'hc0)
    else $error("high reference did not give full scale");

  AST_LOREF: assert property (conv_done && q.ch[4:3] != 2'h0 && q.ch != `ADC_CH_HIREF && q.cc == 3'h0
                              |=> q.res.hi == 8'h00 && q.res.lo == 8'h00)
    else $error("low reference gave nonzero result");

  // control and pin enable writes never let the running count finish
  AST_NO_DONE: assert property (pe_wr || cc_wr |=> !conv_done)
    else $error("aborted conversion still completed");

  // the sequencer count never runs past the last cycle
  AST_CNT_RANGE: assert property (q.conv == adcrg_pkg::ADCRG_BUSY |-> q.cnt <= `ADC_CONV_LAST)
    else $error("conversion count out of range");

  // the core reads only the second synchroniser stage
  AST_SYNC: assert property (q.ain_s == $past(q.ain_m))
    else $error("pin synchroniser skipped a stage");

endmodule

// file: sim/adcrg_ain_model.sv
// analog input model: supplies the code seen on each of the eight pins
module adcrg_ain_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        bump,
  output logic [7:0][9:0]  ain_code
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [9:0] ofs_q;

  // offset moves on request so that a fresh sample differs from the last
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ofs_q <= 10'h000;
    end else if (bump) begin
      ofs_q <= ofs_q + 10'h0d3;
    end
  end

  // distinct code per pin, both ends of the word populated to expose swaps
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ain_code[i] = 10'h2c6 + 10'(i * 10'h049) + ofs_q;
    end
  end
endmodule

// file: sim/adc_control_status_result_regs_test.sv
// self-checking bench for the converter register block
`include "adcrg_cfg.svh"
`define ADCRG_CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_errors++; $display("Error at %0t: got %h, expected %h", $time, (a), (e)); end end

module adc_control_status_result_regs_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic             aclk = 1'b0;
  logic             aresetn = 1'b0;
  logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]       awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]      wdata = 32'h0;
  logic             awready, wready, bvalid, arready, rvalid, conv_irq, bump = 1'b0;
  logic [1:0]       bresp, rresp, resp;
  logic [31:0]      rdata, rd;
  logic [7:0][9:0]  ain_code;
  logic [7:0]       pe_v = 8'h00;
  logic [15:0]      e;
  int               n_errors = 0;
  int               samples_checked = 0;
  localparam logic [2:0] J = 3'(1 << `ADC_CC_JUST);
  localparam logic [2:0] S = 3'(1 << `ADC_CC_SGN);
  localparam logic [2:0] B = 3'(1 << `ADC_CC_EIGHT_BIT_RESOLUTION);
  localparam logic [2:0] FMTS [6] = '{J, J | S, S, B, B | S, B | J};
  localparam logic [7:0] OFS [5] = '{`ADC_OFS_CSC, `ADC_OFS_RHI, `ADC_OFS_RLO, `ADC_OFS_PE, `ADC_OFS_CC};
  localparam logic [4:0] REFS [4] = '{5'h1f, 5'h08, 5'h1d, 5'h1e};

  adcrg_top i_adcrg_top (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .ain_code(ain_code), .conv_irq(conv_irq));
  adcrg_ain_model i_adcrg_ain_model (.aclk(aclk), .aresetn(aresetn), .bump(bump), .ain_code(ain_code));

  // 100 MHz clock
  always #5 aclk = ~aclk;

  // ----------------------------------------
  // bus tasks and expectations
  // ----------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
    axr(a, rd, resp);
    `ADCRG_CHK(rd, x)
    `ADCRG_CHK(resp, `ADC_RESP_OK)
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    pe_v = 8'h00;
  endtask

  // software polling of the done flag, bounded
  task automatic wait_flag();
    int n = 0;
    do begin
      axr(`ADC_OFS_CSC, rd, resp);
      n++;
    end while (rd[`ADC_CSC_FLAG] !== 1'b1 && n < 80);
    `ADCRG_CHK(rd[`ADC_CSC_FLAG], 1'b1)
  endtask

  task automatic wait_irq();
    int n = 0;
    while (conv_irq !== 1'b1 && n < 150) begin
      @(posedge aclk);
      n++;
    end
    `ADCRG_CHK(conv_irq, 1'b1)
  endtask

  function automatic logic [9:0] exp_code(input logic [4:0] ch);
    if (ch < 5'h08) return pe_v[ch[2:0]] ? ain_code[ch[2:0]] : `ADC_CODE_LO;
    return (ch == `ADC_CH_HIREF) ? `ADC_CODE_HI : `ADC_CODE_LO;
  endfunction

  // sign handling only when left justified; eight-bit always in the high byte
  function automatic logic [15:0] fmt(input logic [9:0] r, input logic [2:0] c);
    logic s;
    s = c[`ADC_CC_SGN] & ~c[`ADC_CC_JUST];
    if (c[`ADC_CC_EIGHT_BIT_RESOLUTION]) return {r[9] ^ s, r[8:2], 8'h00};
    if (c[`ADC_CC_JUST]) return {6'h00, r};
    return {r[9] ^ s, r[8:0], 6'h00};
  endfunction

  task automatic run_conv(input logic [7:0] csc, input logic [2:0] c);
    axw(`ADC_OFS_CC, {29'h0, c}, resp);
    axw(`ADC_OFS_CSC, {24'h0, csc}, resp);
    wait_flag();
    e = fmt(exp_code(csc[4:0]), c);
    `ADCRG_CHK(conv_irq, 1'b0)
    rd_chk(`ADC_OFS_RHI, {24'h0, e[15:8]});
    rd_chk(`ADC_OFS_RLO, {24'h0, e[7:0]});
    rd_chk(`ADC_OFS_CSC, {24'h0, csc & 8'h7f});
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // watchdog and main sequence
  // ----------------------------------------
  // expected run is well under 10000 cycles
  initial begin
    #500us;
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run();
  end

  initial begin
    do_reset();
    `ADCRG_CHK(conv_irq, 1'b0)
    for (int i = 0; i < 5; i++) rd_chk(OFS[i], 32'h0);
    axw(`ADC_OFS_PE, 32'hff, resp);
    pe_v = 8'hff;
    for (int ch = 0; ch < 8; ch++) run_conv(8'(ch), 3'h0);
    for (int i = 0; i < 4; i++) run_conv({3'h0, REFS[i]}, 3'h0);
    axw(`ADC_OFS_RHI, 32'h00, resp);
    axw(`ADC_OFS_RLO, 32'h00, resp);
    `ADCRG_CHK(resp, `ADC_RESP_OK)
    rd_chk(`ADC_OFS_RHI, 32'hff);
    rd_chk(`ADC_OFS_RLO, 32'hc0);
    repeat (250) @(posedge aclk);
    rd_chk(`ADC_OFS_CSC, 32'h1e);
    for (int i = 0; i < 6; i++) run_conv(8'h03, FMTS[i]);
    axw(`ADC_OFS_PE, 32'h7f, resp);
    pe_v = 8'h7f;
    run_conv(8'h07, 3'h0);
    axw(8'h14, 32'h1, resp);
    `ADCRG_CHK(resp, `ADC_RESP_ERR)
    axr(8'h14, rd, resp);
    `ADCRG_CHK(resp, `ADC_RESP_ERR)
    // interrupt raised, held, cleared by a status/control write and by a result read
    axw(`ADC_OFS_CC, 32'h0, resp);
    axw(`ADC_OFS_CSC, 32'h42, resp);
    wait_irq();
    repeat (20) @(posedge aclk);
    `ADCRG_CHK(conv_irq, 1'b1)
    axw(`ADC_OFS_CSC, 32'h42, resp);
    rd_chk(`ADC_OFS_CSC, 32'h42);
    `ADCRG_CHK(conv_irq, 1'b0)
    wait_irq();
    e = fmt(exp_code(5'h02), 3'h0);
    rd_chk(`ADC_OFS_RHI, {24'h0, e[15:8]});
    repeat (2) @(posedge aclk);
    `ADCRG_CHK(conv_irq, 1'b0)
    // aborts and restart
    axw(`ADC_OFS_CSC, 32'h01, resp);
    repeat (40) @(posedge aclk);
    axw(`ADC_OFS_PE, 32'hff, resp);
    pe_v = 8'hff;
    repeat (200) @(posedge aclk);
    rd_chk(`ADC_OFS_CSC, 32'h01);
    axw(`ADC_OFS_CSC, 32'h01, resp);
    repeat (40) @(posedge aclk);
    axw(`ADC_OFS_CC, 32'h0, resp);
    repeat (200) @(posedge aclk);
    rd_chk(`ADC_OFS_CSC, 32'h01);
    axw(`ADC_OFS_CSC, 32'h01, resp);
    repeat (60) @(posedge aclk);
    axw(`ADC_OFS_CSC, 32'h01, resp);
    repeat (60) @(posedge aclk);
    rd_chk(`ADC_OFS_CSC, 32'h01);
    wait_flag();
    // continuous mode picks up a changed input on the next conversion
    axw(`ADC_OFS_CSC, 32'h24, resp);
    wait_flag();
    e = fmt(exp_code(5'h04), 3'h0);
    rd_chk(`ADC_OFS_RHI, {24'h0, e[15:8]});
    bump <= 1'b1;
    @(posedge aclk);
    bump <= 1'b0;
    wait_flag();
    e = fmt(exp_code(5'h04), 3'h0);
    rd_chk(`ADC_OFS_RHI, {24'h0, e[15:8]});
    axw(`ADC_OFS_PE, 32'hff, resp);
    axr(`ADC_OFS_RLO, rd, resp);
    repeat (250) @(posedge aclk);
    rd_chk(`ADC_OFS_CSC, 32'h24);
    // completion and a result read on the same edge: the set must win
    axw(`ADC_OFS_CSC, 32'h05, resp);
    repeat (97) @(posedge aclk);
    axr(`ADC_OFS_RLO, rd, resp);
    rd_chk(`ADC_OFS_CSC, 32'h85);
    // reset while an interrupt is pending
    axw(`ADC_OFS_CSC, 32'h42, resp);
    wait_irq();
    do_reset();
    `ADCRG_CHK(conv_irq, 1'b0)
    complete_run();
  end
endmodule
